/* pirq_flags.sv */
`timescale 1ns/100ps
`default_nettype none

module pirq_flags (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire pirq_pkg::pirq_evt_t set_evt,
    input  wire pirq_pkg::pirq_evt_t clr_w1c,
    output var  pirq_pkg::pirq_evt_t flags
);

    typedef struct packed {
        pirq_pkg::pirq_evt_t flag;
    } pirq_flags_s;

    pirq_flags_s         s_q;
    pirq_flags_s         s_d;
    pirq_pkg::pirq_evt_t nxt;

    // Set wins over a clear in the same cycle so that no event is lost.
    for (genvar i = 0; i < pirq_pkg::NUM_FLAGS; i++)
    begin : g_flag
        assign nxt[i] = set_evt[i] | (s_q.flag[i] & ~clr_w1c[i]);
    end

    always_comb
    begin
        s_d      = s_q;
        s_d.flag = nxt;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '{flag: pirq_pkg::FLAGS_RESET};
        else
            s_q <= s_d;
    end

    assign flags = s_q.flag;

    property p_w1c_clears;
        @(posedge mclk) disable iff (!arst_n)
        (clr_w1c[0] && !set_evt[0]) |=> !flags[0];
    endproperty
    a_w1c_clears: assert property (p_w1c_clears) else $error("flag not cleared by write one");

    property p_zero_keeps;
        @(posedge mclk) disable iff (!arst_n)
        (flags != '0) && (clr_w1c == '0) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost without write one");

endmodule // pirq_flags

`default_nettype wire

/* pirq_host.sv */
`timescale 1ns/100ps
`default_nettype none

module pirq_host (
    input  wire logic       mclk,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr_stb,
    output logic            rd_stb
);
    initial
    begin
        addr   = 8'h00;
        wdata  = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // Each access ends with an idle cycle, so a strobe is never driven twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
        @(posedge mclk);
    endtask
endmodule // pirq_host

`default_nettype wire

/* pirq_pkg.sv */
`default_nettype none

package pirq_pkg;

    localparam logic [7:0] ADDR_PART_IDENTITY      = 8'h00;
    localparam logic [7:0] ADDR_SILICON_REVISION   = 8'h03;
    localparam logic [7:0] ADDR_FABRICATION_SOURCE = 8'h04;
    localparam logic [7:0] ADDR_EVENT_FLAGS        = 8'h05;
    localparam logic [7:0] ADDR_EVENT_MASKS        = 8'h06;
    localparam logic [7:0] ADDR_LIVE_CONDITIONS    = 8'h07;
    localparam logic [7:0] ADDR_SCRATCH_A          = 8'h1C;
    localparam logic [7:0] ADDR_SCRATCH_B          = 8'h1D;
    localparam logic [7:0] ADDR_SCRATCH_C          = 8'h1E;
    localparam logic [7:0] ADDR_SCRATCH_D          = 8'h1F;

    localparam int NUM_FLAGS   = 6;
    localparam int NUM_SCRATCH = 4;

    localparam int BIT_TURN_ON     = 0;
    localparam int BIT_UNDERVOLT   = 1;
    localparam int BIT_HOT_LOW     = 2;
    localparam int BIT_HOT_TOP     = 5;
    localparam int BIT_FUSE_SUPPLY = 7;

    localparam logic [5:0] FLAGS_RESET   = 6'h00;
    localparam logic [5:0] MASKS_RESET   = 6'h3F;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET   = 8'h00;

    typedef logic [NUM_FLAGS-1:0] pirq_evt_t;

endpackage

`default_nettype wire

/* pirq_regs.sv */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Identity register is fixed read-only: part code in 3:0, family in 7:4.
// - Revision register reads metal-mask code in 3:0, full-mask code in 7:4.
// - Fabrication register: reticle option in 1:0, wafer site in 3:2, rest zero.
// - Four independent 8-bit scratch bytes reset to zero and hold last write.
// - Scratch bytes live on backup power; only the backup reset clears them.
// - A flag stays set until written with one; writing zero leaves it.
// - Thermal flags 5..2 latch on any threshold crossing, rising or falling.
// - Flag 1 latches when the input undervoltage detector reports an event.
// - Flag 0 latches on each turn-on event.
// - Mask bit zero lets its flag drive the interrupt pin; one blocks it.
// - Mask register holds six writable mask bits at positions 5 to 0.
// - Sense bits are read-only and show the present live conditions.
// - Sense bit 7 shows whether the fuse programming supply is present.
// - Sense bit 0 follows the turn-on request pin level.
// - Sense bits have no fixed reset value; they show inputs from the start.
// - Flag and mask registers can be read and written at any time.
module pirq_regs #(
    parameter logic [3:0] PART_CODE           = 4'h5, // Arbitrary value.
    parameter logic [3:0] FAMILY_CODE         = 4'hA, // Arbitrary value.
    parameter logic [3:0] METAL_MASK_REVISION = 4'h2, // Arbitrary value.
    parameter logic [3:0] FULL_MASK_REVISION  = 4'h7, // Arbitrary value.
    parameter logic [1:0] RETICLE_OPTION_CODE = 2'h2, // Arbitrary value.
    parameter logic [1:0] WAFER_SITE_CODE     = 2'h2  // Arbitrary value.
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       backup_power_on_reset_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [7:0]      rdata,
    input  wire logic       hot_live_top,
    input  wire logic       hot_live_high,
    input  wire logic       hot_live_mid,
    input  wire logic       hot_live_low,
    input  wire logic       input_undervolt_live,
    input  wire logic       turn_on_request_pin,
    input  wire logic       fuse_supply_live,
    output logic            irq_out_n
);

    typedef struct packed {
        pirq_pkg::pirq_evt_t prev;
        logic                primed;
        pirq_pkg::pirq_evt_t mask;
        logic [7:0]          rdata;
        logic                irq_n;
    } pirq_state_s;

    pirq_state_s         s_q;
    pirq_state_s         s_d;
    pirq_pkg::pirq_evt_t live_now;
    pirq_pkg::pirq_evt_t set_evt;
    pirq_pkg::pirq_evt_t clr_w1c;
    pirq_pkg::pirq_evt_t flags;
    logic [3:0][7:0]     scratch;
    logic                scratch_wr;
    logic [1:0]          scratch_sel;

    assign live_now = {hot_live_top, hot_live_high, hot_live_mid, hot_live_low,
                       input_undervolt_live, turn_on_request_pin};

    // Thermal and undervoltage edges are only judged once a first sample has been taken after reset,
    // so the reset release itself never looks like a thermal crossing.
    always_comb
    begin
        set_evt = '0;
        set_evt[pirq_pkg::BIT_HOT_TOP:pirq_pkg::BIT_HOT_LOW] =
            {4{s_q.primed}} & (live_now[pirq_pkg::BIT_HOT_TOP:pirq_pkg::BIT_HOT_LOW]
                               ^ s_q.prev[pirq_pkg::BIT_HOT_TOP:pirq_pkg::BIT_HOT_LOW]);
        set_evt[pirq_pkg::BIT_UNDERVOLT] = s_q.primed & live_now[pirq_pkg::BIT_UNDERVOLT]
                                           & ~s_q.prev[pirq_pkg::BIT_UNDERVOLT];
        // A request already present at reset release counts as a turn-on event.
        set_evt[pirq_pkg::BIT_TURN_ON] = live_now[pirq_pkg::BIT_TURN_ON]
                                         & (~s_q.prev[pirq_pkg::BIT_TURN_ON] | ~s_q.primed);
    end

    assign clr_w1c = (wr_stb && addr == pirq_pkg::ADDR_EVENT_FLAGS) ? wdata[5:0] : '0;

    always_comb
    begin
        scratch_wr  = 1'b0;
        scratch_sel = 2'h0;
        unique case (addr)
            pirq_pkg::ADDR_SCRATCH_A:
            begin
                scratch_wr  = wr_stb;
                scratch_sel = 2'h0;
            end
            pirq_pkg::ADDR_SCRATCH_B:
            begin
                scratch_wr  = wr_stb;
                scratch_sel = 2'h1;
            end
            pirq_pkg::ADDR_SCRATCH_C:
            begin
                scratch_wr  = wr_stb;
                scratch_sel = 2'h2;
            end
            pirq_pkg::ADDR_SCRATCH_D:
            begin
                scratch_wr  = wr_stb;
                scratch_sel = 2'h3;
            end
            default:
            begin
                scratch_wr  = 1'b0;
                scratch_sel = 2'h0;
            end
        endcase
    end

    pirq_flags u_flags (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .set_evt (set_evt),
        .clr_w1c (clr_w1c),
        .flags   (flags)
    );

    pirq_scratch u_scratch (
        .mclk                    (mclk),
        .backup_power_on_reset_n (backup_power_on_reset_n),
        .wr_en                   (scratch_wr),
        .sel                     (scratch_sel),
        .wdata                   (wdata),
        .bytes                   (scratch)
    );

    always_comb
    begin
        s_d        = s_q;
        s_d.primed = 1'b1;
        s_d.prev   = live_now;
        if (wr_stb && addr == pirq_pkg::ADDR_EVENT_MASKS)
            s_d.mask = wdata[5:0];
        s_d.rdata = pirq_pkg::RDATA_RESET;
        if (rd_stb)
        begin
            unique case (addr)
                pirq_pkg::ADDR_PART_IDENTITY:      s_d.rdata = {FAMILY_CODE, PART_CODE};
                pirq_pkg::ADDR_SILICON_REVISION:   s_d.rdata = {FULL_MASK_REVISION, METAL_MASK_REVISION};
                pirq_pkg::ADDR_FABRICATION_SOURCE: s_d.rdata = {4'h0, WAFER_SITE_CODE, RETICLE_OPTION_CODE};
                pirq_pkg::ADDR_EVENT_FLAGS:        s_d.rdata = {2'h0, flags};
                pirq_pkg::ADDR_EVENT_MASKS:        s_d.rdata = {2'h0, s_q.mask};
                // Sense reads the inputs directly, so no reset value applies.
                pirq_pkg::ADDR_LIVE_CONDITIONS:    s_d.rdata = {fuse_supply_live, 1'b0, live_now};
                pirq_pkg::ADDR_SCRATCH_A:          s_d.rdata = scratch[0];
                pirq_pkg::ADDR_SCRATCH_B:          s_d.rdata = scratch[1];
                pirq_pkg::ADDR_SCRATCH_C:          s_d.rdata = scratch[2];
                pirq_pkg::ADDR_SCRATCH_D:          s_d.rdata = scratch[3];
                default:                           s_d.rdata = pirq_pkg::RDATA_RESET;
            endcase
        end
        // The pin lags the flags by one cycle; the trade buys a glitch-free registered output.
        s_d.irq_n = ~|(flags & ~s_q.mask);
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '{prev:   '0,
                     primed: 1'b0,
                     mask:   pirq_pkg::MASKS_RESET,
                     rdata:  pirq_pkg::RDATA_RESET,
                     irq_n:  1'b1};
        else
            s_q <= s_d;
    end

    assign rdata     = s_q.rdata;
    assign irq_out_n = s_q.irq_n;

    property p_part_identity;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_PART_IDENTITY |=> rdata == {FAMILY_CODE, PART_CODE};
    endproperty
    a_part_identity: assert property (p_part_identity) else $error("identity read wrong");

    property p_part_fixed;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_PART_IDENTITY ##1 !wr_stb
        ##1 rd_stb && addr == pirq_pkg::ADDR_PART_IDENTITY
        |=> rdata == {FAMILY_CODE, PART_CODE};
    endproperty
    a_part_fixed: assert property (p_part_fixed) else $error("identity changed by write");

    property p_revision;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_SILICON_REVISION
        |=> rdata[7:4] == FULL_MASK_REVISION && rdata[3:0] == METAL_MASK_REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision read wrong");

    property p_fabrication;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_FABRICATION_SOURCE
        |=> rdata == {4'h0, WAFER_SITE_CODE, RETICLE_OPTION_CODE};
    endproperty
    a_fabrication: assert property (p_fabrication) else $error("fabrication read wrong");

    property p_scratch_roundtrip;
        @(posedge mclk) disable iff (!arst_n || !backup_power_on_reset_n)
        wr_stb && addr == pirq_pkg::ADDR_SCRATCH_C ##1 !wr_stb
        ##1 rd_stb && addr == pirq_pkg::ADDR_SCRATCH_C
        |=> rdata == $past(wdata, 3);
    endproperty
    a_scratch_roundtrip: assert property (p_scratch_roundtrip) else $error("scratch lost write");

    property p_hot_crossing;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && (hot_live_mid != s_q.prev[3]) |=> flags[3] ##1 (flags[3] || $past(clr_w1c[3]));
    endproperty
    a_hot_crossing: assert property (p_hot_crossing) else $error("thermal crossing not latched");

    property p_hot_fall;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && !hot_live_top && s_q.prev[pirq_pkg::BIT_HOT_TOP] |=> flags[pirq_pkg::BIT_HOT_TOP];
    endproperty
    a_hot_fall: assert property (p_hot_fall) else $error("falling crossing not latched");

    property p_undervolt;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && $rose(input_undervolt_live) |=> flags[pirq_pkg::BIT_UNDERVOLT];
    endproperty
    a_undervolt: assert property (p_undervolt) else $error("undervolt not latched");

    property p_turn_on;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && !s_q.prev[0] && turn_on_request_pin |=> flags[pirq_pkg::BIT_TURN_ON];
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("turn-on not latched");

    property p_irq_unmasked;
        @(posedge mclk) disable iff (!arst_n)
        (flags[1] && !s_q.mask[1]) |=> !irq_out_n;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) else $error("unmasked flag gives no interrupt");

    property p_irq_quiet;
        @(posedge mclk) disable iff (!arst_n)
        ((flags & ~s_q.mask) == '0) |=> irq_out_n;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without unmasked flag");

    property p_mask_write;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_EVENT_MASKS ##1 !wr_stb
        ##1 rd_stb && addr == pirq_pkg::ADDR_EVENT_MASKS
        |=> rdata == {2'h0, $past(wdata[5:0], 3)};
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not kept");

    property p_sense_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_LIVE_CONDITIONS
        |=> rdata[pirq_pkg::BIT_FUSE_SUPPLY] == $past(fuse_supply_live) && rdata[0] == $past(turn_on_request_pin)
            && rdata[5:1] == $past(live_now[5:1]) && !rdata[6];
    endproperty
    a_sense_read: assert property (p_sense_read) else $error("sense read wrong");

    property p_read_only_once;
        @(posedge mclk) disable iff (!arst_n)
        !rd_stb |=> rdata == pirq_pkg::RDATA_RESET;
    endproperty
    a_read_only_once: assert property (p_read_only_once) else $error("read data outside its cycle");

    property p_hot_top_rise;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && hot_live_top && !s_q.prev[pirq_pkg::BIT_HOT_TOP] |=> flags[pirq_pkg::BIT_HOT_TOP];
    endproperty
    a_hot_top_rise: assert property (p_hot_top_rise) else $error("rising crossing not latched");

    property p_hot_high;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && (hot_live_high != s_q.prev[4]) |=> flags[4];
    endproperty
    a_hot_high: assert property (p_hot_high) else $error("second threshold crossing not latched");

    property p_hot_low;
        @(posedge mclk) disable iff (!arst_n)
        s_q.primed && (hot_live_low != s_q.prev[pirq_pkg::BIT_HOT_LOW]) |=> flags[pirq_pkg::BIT_HOT_LOW];
    endproperty
    a_hot_low: assert property (p_hot_low) else $error("lowest threshold crossing not latched");

    // The release edge itself is left out, because the flags are still held in reset there.
    property p_turn_on_first;
        @(posedge mclk) disable iff (!arst_n)
        arst_n && !s_q.primed && turn_on_request_pin |=> flags[pirq_pkg::BIT_TURN_ON];
    endproperty
    a_turn_on_first: assert property (p_turn_on_first) else $error("turn-on at start not latched");

    property p_w1c_bus;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_EVENT_FLAGS |=> (flags & $past(wdata[5:0] & ~set_evt)) == '0;
    endproperty
    a_w1c_bus: assert property (p_w1c_bus) else $error("flag survived a write of one");

    property p_w1c_keep;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_EVENT_FLAGS
        |=> (flags & $past(flags & ~wdata[5:0])) == $past(flags & ~wdata[5:0]);
    endproperty
    a_w1c_keep: assert property (p_w1c_keep) else $error("flag cleared by a write of zero");

    property p_irq_any;
        @(posedge mclk) disable iff (!arst_n)
        (flags & ~s_q.mask) != '0 |=> !irq_out_n;
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("unmasked flag left pin released");

    property p_flags_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_EVENT_FLAGS |=> rdata == {2'h0, $past(flags)};
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flag read wrong");

    property p_mask_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_EVENT_MASKS |=> rdata == {2'h0, $past(s_q.mask)};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

    property p_scratch_a_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_SCRATCH_A |=> rdata == $past(scratch[0]);
    endproperty
    a_scratch_a_read: assert property (p_scratch_a_read) else $error("first scratch read wrong");

    property p_scratch_d_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_stb && addr == pirq_pkg::ADDR_SCRATCH_D |=> rdata == $past(scratch[3]);
    endproperty
    a_scratch_d_read: assert property (p_scratch_d_read) else $error("last scratch read wrong");

    property p_revision_fixed;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_SILICON_REVISION ##1 !wr_stb
        ##1 rd_stb && addr == pirq_pkg::ADDR_SILICON_REVISION
        |=> rdata == {FULL_MASK_REVISION, METAL_MASK_REVISION};
    endproperty
    a_revision_fixed: assert property (p_revision_fixed) else $error("revision changed by write");

    property p_fab_fixed;
        @(posedge mclk) disable iff (!arst_n)
        wr_stb && addr == pirq_pkg::ADDR_FABRICATION_SOURCE ##1 !wr_stb
        ##1 rd_stb && addr == pirq_pkg::ADDR_FABRICATION_SOURCE
        |=> rdata == {4'h0, WAFER_SITE_CODE, RETICLE_OPTION_CODE};
    endproperty
    a_fab_fixed: assert property (p_fab_fixed) else $error("fabrication changed by write");

endmodule // pirq_regs

`default_nettype wire

/* pirq_scratch.sv */
`timescale 1ns/100ps
`default_nettype none

module pirq_scratch (
    input  wire logic            mclk,
    input  wire logic            backup_power_on_reset_n,
    input  wire logic            wr_en,
    input  wire logic [1:0]      sel,
    input  wire logic [7:0]      wdata,
    output logic [3:0][7:0]      bytes
);

    typedef struct packed {
        logic [3:0][7:0] bank;
    } pirq_scratch_s;

    pirq_scratch_s s_q;
    pirq_scratch_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (wr_en)
            s_d.bank[sel] = wdata;
    end

    // Only the backup-cell reset reaches these bytes; the main reset does not.
    always_ff @(posedge mclk or negedge backup_power_on_reset_n)
    begin
        if (!backup_power_on_reset_n)
            s_q <= '{bank: {pirq_pkg::NUM_SCRATCH{pirq_pkg::SCRATCH_RESET}}};
        else
            s_q <= s_d;
    end

    assign bytes = s_q.bank;

    property p_scratch_hold;
        @(posedge mclk) disable iff (!backup_power_on_reset_n)
        !wr_en |=> $stable(bytes);
    endproperty
    a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed without a write");

endmodule // pirq_scratch

`default_nettype wire

/* test_pirq_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module test_pirq_regs;
    logic       mclk;
    logic       arst_n;
    logic       backup_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr_stb;
    logic       rd_stb;
    logic       irq_out_n;
    logic [5:0] live_v;
    logic       fuse;
    int         err_total  = 0;
    int         num_checks = 0;

    always #20 mclk = ~mclk;

    pirq_regs pirq_regs_inst (
        .mclk                    (mclk),
        .arst_n                  (arst_n),
        .backup_power_on_reset_n (backup_n),
        .addr                    (addr),
        .wdata                   (wdata),
        .wr_stb                  (wr_stb),
        .rd_stb                  (rd_stb),
        .rdata                   (rdata),
        .hot_live_top            (live_v[5]),
        .hot_live_high           (live_v[4]),
        .hot_live_mid            (live_v[3]),
        .hot_live_low            (live_v[2]),
        .input_undervolt_live    (live_v[1]),
        .turn_on_request_pin     (live_v[0]),
        .fuse_supply_live        (fuse),
        .irq_out_n               (irq_out_n)
    );

    pirq_host pirq_host_inst (
        .mclk   (mclk),
        .rdata  (rdata),
        .addr   (addr),
        .wdata  (wdata),
        .wr_stb (wr_stb),
        .rd_stb (rd_stb)
    );

    task automatic finish_test;
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        pirq_host_inst.rd(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pirq_host_inst.wr(a, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic irq_chk(input logic exp);
        #1;
        chk({7'h00, irq_out_n}, {7'h00, exp});
    endtask

    task automatic do_reset;
        arst_n <= 1'b0;
        tick(3);
        arst_n <= 1'b1;
        tick(1);
    endtask

    task automatic t_ids;
        rchk(pirq_pkg::ADDR_PART_IDENTITY, 8'hA5);
        wr(pirq_pkg::ADDR_PART_IDENTITY, 8'h00);
        rchk(pirq_pkg::ADDR_PART_IDENTITY, 8'hA5);
        rchk(pirq_pkg::ADDR_SILICON_REVISION, 8'h72);
        wr(pirq_pkg::ADDR_SILICON_REVISION, 8'h00);
        rchk(pirq_pkg::ADDR_SILICON_REVISION, 8'h72);
        rchk(pirq_pkg::ADDR_FABRICATION_SOURCE, 8'h0A);
        wr(pirq_pkg::ADDR_FABRICATION_SOURCE, 8'hFF);
        rchk(pirq_pkg::ADDR_FABRICATION_SOURCE, 8'h0A);
        rchk(8'h40, 8'h00);
    endtask

    task automatic t_scratch;
        logic [7:0] pat [4];
        pat = '{8'h01, 8'h80, 8'hFF, 8'h5A};
        for (int i = 0; i < 4; i++)
            rchk(pirq_pkg::ADDR_SCRATCH_A + 8'(i), 8'h00);
        for (int i = 0; i < 4; i++)
            wr(pirq_pkg::ADDR_SCRATCH_A + 8'(i), pat[i]);
        for (int i = 0; i < 4; i++)
            rchk(pirq_pkg::ADDR_SCRATCH_A + 8'(i), pat[i]);
        do_reset();
        for (int i = 0; i < 4; i++)
            rchk(pirq_pkg::ADDR_SCRATCH_A + 8'(i), pat[i]);
        backup_n <= 1'b0;
        tick(2);
        backup_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++)
            rchk(pirq_pkg::ADDR_SCRATCH_A + 8'(i), 8'h00);
        wr(pirq_pkg::ADDR_SCRATCH_C, 8'h3C);
        rchk(pirq_pkg::ADDR_SCRATCH_C, 8'h3C);
    endtask

    task automatic t_masks;
        rchk(pirq_pkg::ADDR_EVENT_MASKS, 8'h3F);
        rchk(pirq_pkg::ADDR_EVENT_FLAGS, 8'h00);
        irq_chk(1'b1);
        wr(pirq_pkg::ADDR_EVENT_MASKS, 8'hFF);
        rchk(pirq_pkg::ADDR_EVENT_MASKS, 8'h3F);
        wr(pirq_pkg::ADDR_EVENT_MASKS, 8'h00);
        rchk(pirq_pkg::ADDR_EVENT_MASKS, 8'h00);
    endtask

    // Thermal flags latch both ways; undervolt and turn-on only on a rise.
    task automatic t_events;
        logic [7:0] m;
        for (int b = 0; b < 6; b++)
        begin
            m = 8'h01 << b;
            live_v[b] <= 1'b1;
            tick(3);
            rchk(pirq_pkg::ADDR_EVENT_FLAGS, m);
            irq_chk(1'b0);
            wr(pirq_pkg::ADDR_EVENT_FLAGS, ~m & 8'h3F);
            rchk(pirq_pkg::ADDR_EVENT_FLAGS, m);
            wr(pirq_pkg::ADDR_EVENT_FLAGS, m);
            tick(2);
            rchk(pirq_pkg::ADDR_EVENT_FLAGS, 8'h00);
            irq_chk(1'b1);
            live_v[b] <= 1'b0;
            tick(3);
            rchk(pirq_pkg::ADDR_EVENT_FLAGS, (b >= 2) ? m : 8'h00);
            wr(pirq_pkg::ADDR_EVENT_FLAGS, m);
            tick(2);
        end
    endtask

    task automatic t_gate;
        wr(pirq_pkg::ADDR_EVENT_MASKS, 8'h3F);
        live_v[3] <= 1'b1;
        tick(3);
        irq_chk(1'b1);
        wr(pirq_pkg::ADDR_EVENT_MASKS, 8'h37);
        tick(2);
        irq_chk(1'b0);
        wr(pirq_pkg::ADDR_EVENT_MASKS, 8'h3F);
        tick(2);
        irq_chk(1'b1);
        rchk(pirq_pkg::ADDR_EVENT_FLAGS, 8'h08);
        wr(pirq_pkg::ADDR_EVENT_FLAGS, 8'h08);
    endtask

    task automatic t_sense;
        live_v <= 6'h25;
        fuse   <= 1'b1;
        do_reset();
        rchk(pirq_pkg::ADDR_LIVE_CONDITIONS, 8'hA5);
        rchk(pirq_pkg::ADDR_EVENT_FLAGS, 8'h01);
        wr(pirq_pkg::ADDR_LIVE_CONDITIONS, 8'h00);
        rchk(pirq_pkg::ADDR_LIVE_CONDITIONS, 8'hA5);
        live_v <= 6'h1A;
        fuse   <= 1'b0;
        tick(1);
        rchk(pirq_pkg::ADDR_LIVE_CONDITIONS, 8'h1A);
    endtask

    initial
    begin
        mclk     = 1'b0;
        arst_n   = 1'b0;
        backup_n = 1'b0;
        live_v   = 6'h00;
        fuse     = 1'b0;
        tick(3);
        arst_n   <= 1'b1;
        backup_n <= 1'b1;
        tick(1);
        t_ids();
        t_scratch();
        t_masks();
        t_events();
        t_gate();
        t_sense();
        finish_test();
    end

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule // test_pirq_regs

`default_nettype wire
